// ### pkg/oosc_pkg.sv
package oosc_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 250_000_000;
  // Nominal switching frequency variants
  localparam int unsigned FSW_66_HZ = 66_000;
  localparam int unsigned FSW_83_HZ = 83_000;
  localparam int unsigned FSW_100_HZ = 100_000;
  // Jitter depth in percent and modulation rate
  localparam int unsigned JIT_PCT = 5;
  localparam int unsigned JIT_MOD_HZ = 1_000;
  // Foldback floor in percent of nominal
  localparam int unsigned FOLD_MIN_PCT = 48;
  // Foldback span in millivolts, 1.69 V down to 0.8 V
  localparam int unsigned FOLD_HI_MV = 1690;
  localparam int unsigned FOLD_LO_MV = 800;
  // Auto-restart timing in milliseconds
  localparam int unsigned AR_DET_MS = 100;
  localparam int unsigned AR_OFF_MS = 800;
  localparam int unsigned AR_ON_MS = 100;
  // Max duty window in percent of period
  localparam int unsigned DMAX_PCT = 65;
  // Blanking time in nanoseconds
  localparam int unsigned LEB_NS = 200;
  localparam int unsigned LEB_CYC = (LEB_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Fold level code width; code 0 is 0.8 V, full scale is 1.69 V or more
  localparam int unsigned FOLD_W = 4;
  typedef enum logic [1:0] {OOSC_RUN, OOSC_ON, OOSC_OFF} oosc_ar_t;
endpackage

// ### hdl/oosc_on_off_switch_controller.sv
`timescale 1ns/100ps
module oosc_on_off_switch_controller #(
  parameter int unsigned FSW_HZ = oosc_pkg::FSW_66_HZ,
  parameter int unsigned AR_DET_CYC = oosc_pkg::AR_DET_MS * (oosc_pkg::CLK_HZ / 1000),
  parameter int unsigned AR_OFF_CYC = oosc_pkg::AR_OFF_MS * (oosc_pkg::CLK_HZ / 1000),
  parameter int unsigned AR_ON_CYC = oosc_pkg::AR_ON_MS * (oosc_pkg::CLK_HZ / 1000)
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic fb_current_over,
  input wire logic fb_above_restart,
  input wire logic [oosc_pkg::FOLD_W-1:0] fb_fold_level,
  input wire logic supply_below_low,
  input wire logic supply_above_high,
  input wire logic temp_above_trip,
  input wire logic temp_below_release,
  input wire logic current_over_limit,
  output logic gate_drive,
  output logic cycle_start,
  output logic max_duty_window,
  output logic regulation_enable
);
  localparam int unsigned PER_NOM = oosc_pkg::CLK_HZ / FSW_HZ;
  localparam int unsigned JIT_SPAN = PER_NOM * oosc_pkg::JIT_PCT / 100;
  localparam int unsigned JIT_STEP_CYC = oosc_pkg::CLK_HZ / oosc_pkg::JIT_MOD_HZ / 32;
  localparam int unsigned PER_MAX = (PER_NOM + JIT_SPAN) * 100 / oosc_pkg::FOLD_MIN_PCT + 1;
  localparam int unsigned PW = $clog2(PER_MAX + 1);
  localparam int unsigned CW = $clog2(AR_OFF_CYC + AR_DET_CYC + AR_ON_CYC + 1);
  localparam int unsigned FMAX = (1 << oosc_pkg::FOLD_W) - 1;
  localparam int unsigned JTW = $clog2(JIT_STEP_CYC + 1);
  localparam int unsigned LBW = $clog2(oosc_pkg::LEB_CYC + 1);

  // Refuse parameters the counters cannot serve
  if (FSW_HZ == 0 || PER_NOM < 16 || AR_DET_CYC == 0 || AR_OFF_CYC == 0 || AR_ON_CYC == 0) begin : g_param_check
    $error("oosc: parameter out of range");
  end

  // Input synchronisers
  logic [6:0] s1_q, s1_d, s2_q, s2_d;
  logic [oosc_pkg::FOLD_W-1:0] f1_q, f1_d, f2_q, f2_d;
  always_comb begin
    s1_d = {fb_current_over, fb_above_restart, supply_below_low, supply_above_high,
            temp_above_trip, temp_below_release, current_over_limit};
    s2_d = s1_q;
    f1_d = fb_fold_level;
    f2_d = f1_q;
  end
  always_ff @(posedge mclk) begin
    s1_q <= s1_d;
    s2_q <= s2_d;
    f1_q <= f1_d;
    f2_q <= f2_d;
  end
  logic fbi, fba, sbl, sbh, tat, tbr, col;
  assign {fbi, fba, sbl, sbh, tat, tbr, col} = s2_q;

  // Oscillator
  logic [PW-1:0] ph_q, ph_d, per_q, per_d;
  logic [4:0] jit_q, jit_d;
  logic [JTW-1:0] jt_q, jt_d;
  logic cs_q, cs_d, win_q, win_d;
  logic [PW-1:0] per_base, per_fold;
  always_comb begin
    per_base = PW'(PER_NOM - JIT_SPAN / 2 + (JIT_SPAN * (jit_q[4] ? 31 - jit_q[3:0] * 2 : jit_q[3:0] * 2)) / 31);
    per_fold = PW'(per_base * 100 * FMAX /
      (oosc_pkg::FOLD_MIN_PCT * FMAX + (100 - oosc_pkg::FOLD_MIN_PCT) * f2_q));
    jt_d = (jt_q == 0) ? JTW'(JIT_STEP_CYC - 1) : jt_q - 1'b1;
    jit_d = (jt_q == 0) ? jit_q + 1'b1 : jit_q;
    cs_d = (ph_q == per_q - 1'b1);
    ph_d = cs_d ? '0 : ph_q + 1'b1;
    per_d = cs_d ? per_fold : per_q;
    win_d = cs_d || (ph_q + 1'b1 < PW'((per_q * oosc_pkg::DMAX_PCT) / 100));
    if (!rst_b) begin
      ph_d = '0;
      per_d = PW'(PER_NOM);
      jit_d = '0;
      jt_d = '0;
      cs_d = 1'b0;
      win_d = 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    ph_q <= ph_d;
    per_q <= per_d;
    jit_q <= jit_d;
    jt_q <= jt_d;
    cs_q <= cs_d;
    win_q <= win_d;
  end

  // Protection latches and auto-restart
  logic uv_q, uv_d, ot_q, ot_d;
  oosc_pkg::oosc_ar_t ar_q, ar_d;
  logic [CW-1:0] arc_q, arc_d;
  always_comb begin
    uv_d = sbl ? 1'b1 : (sbh ? 1'b0 : uv_q);
    ot_d = tat ? 1'b1 : (tbr ? 1'b0 : ot_q);
    ar_d = ar_q;
    arc_d = arc_q + 1'b1;
    case (ar_q)
      oosc_pkg::OOSC_RUN: begin
        if (fba) begin
          arc_d = '0;
        end else if (arc_q >= CW'(AR_DET_CYC)) begin
          ar_d = oosc_pkg::OOSC_OFF;
          arc_d = '0;
        end
      end
      oosc_pkg::OOSC_OFF: begin
        if (arc_q >= CW'(AR_OFF_CYC - 1)) begin
          ar_d = oosc_pkg::OOSC_ON;
          arc_d = '0;
        end
      end
      default: begin
        if (fba) begin
          ar_d = oosc_pkg::OOSC_RUN;
          arc_d = '0;
        end else if (arc_q >= CW'(AR_ON_CYC - 1)) begin
          ar_d = oosc_pkg::OOSC_OFF;
          arc_d = '0;
        end
      end
    endcase
    if (!rst_b) begin
      uv_d = 1'b1;
      ot_d = 1'b0;
      ar_d = oosc_pkg::OOSC_RUN;
      arc_d = '0;
    end
  end
  always_ff @(posedge mclk) begin
    uv_q <= uv_d;
    ot_q <= ot_d;
    ar_q <= ar_d;
    arc_q <= arc_d;
  end

  // Gate control
  logic en_q, en_d, gt_q, gt_d, rq_q, rq_d;
  logic [LBW-1:0] lb_q, lb_d;
  logic allow;
  always_comb begin
    allow = !uv_q && !ot_q && (ar_q != oosc_pkg::OOSC_OFF);
    rq_d = !fbi;
    en_d = en_q;
    gt_d = gt_q;
    lb_d = (lb_q != 0) ? lb_q - 1'b1 : lb_q;
    if (cs_q) begin
      en_d = rq_q;
      gt_d = rq_q && allow;
      lb_d = LBW'(oosc_pkg::LEB_CYC);
    end else begin
      if (col && lb_q == 0) begin
        gt_d = 1'b0;
      end
      if (!allow) begin
        gt_d = 1'b0;
      end
    end
    if (!win_d) begin
      gt_d = 1'b0;
    end
    if (!rst_b) begin
      en_d = 1'b0;
      gt_d = 1'b0;
      rq_d = 1'b0;
      lb_d = '0;
    end
  end
  always_ff @(posedge mclk) begin
    en_q <= en_d;
    gt_q <= gt_d;
    rq_q <= rq_d;
    lb_q <= lb_d;
  end

  assign gate_drive = gt_q;
  assign cycle_start = cs_q;
  assign max_duty_window = win_q;
  assign regulation_enable = en_q;

  property p_gate_off_no_enable;
    @(posedge mclk) disable iff (!rst_b) $rose(gt_q) |-> $past(rq_q);
  endproperty
  a_gate_off_no_enable: assert property (p_gate_off_no_enable) else $error("gate without enable");
  property p_enable_held;
    @(posedge mclk) disable iff (!rst_b) !$past(cs_q) |-> $stable(en_q);
  endproperty
  a_enable_held: assert property (p_enable_held) else $error("enable changed mid cycle");
  property p_req_level;
    @(posedge mclk) disable iff (!rst_b) $past(fbi) |-> !rq_q;
  endproperty
  a_req_level: assert property (p_req_level) else $error("enable not low on over current");
  property p_start_pulse;
    @(posedge mclk) disable iff (!rst_b) cs_q |=> !cs_q;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not one cycle");
  property p_uv_block;
    @(posedge mclk) disable iff (!rst_b) uv_q |=> !gt_q;
  endproperty
  a_uv_block: assert property (p_uv_block) else $error("gate during lockout");
  property p_ot_block;
    @(posedge mclk) disable iff (!rst_b) ot_q |=> !gt_q;
  endproperty
  a_ot_block: assert property (p_ot_block) else $error("gate during thermal");
  property p_limit;
    @(posedge mclk) disable iff (!rst_b) gt_q && col && lb_q == 0 && !cs_q |=> !gt_q;
  endproperty
  a_limit: assert property (p_limit) else $error("limit ignored");
  property p_blank;
    @(posedge mclk) disable iff (!rst_b) $rose(gt_q) |-> lb_q != 0;
  endproperty
  a_blank: assert property (p_blank) else $error("no blanking");
  property p_ar_off;
    @(posedge mclk) disable iff (!rst_b) ar_q == oosc_pkg::OOSC_OFF |=> !gt_q;
  endproperty
  a_ar_off: assert property (p_ar_off) else $error("gate in restart off");
  property p_window;
    @(posedge mclk) disable iff (!rst_b) gt_q |-> win_q;
  endproperty
  a_window: assert property (p_window) else $error("gate outside window");
  c_gate: cover property (@(posedge mclk) disable iff (!rst_b) $rose(gt_q));
  c_limit: cover property (@(posedge mclk) disable iff (!rst_b) gt_q ##1 !gt_q && win_q);
  c_restart: cover property (@(posedge mclk) disable iff (!rst_b) ar_q == oosc_pkg::OOSC_OFF);
endmodule // oosc_on_off_switch_controller

// ### testbench/oosc_switch_model.sv
`timescale 1ns/100ps
module oosc_switch_model (
  input wire logic mclk,
  input wire logic gate_drive,
  input wire logic [15:0] trip_cyc,
  output logic current_over_limit
);
  logic [15:0] on_q = 16'h0000;
  logic lim_q = 1'b0;
  // Sense ramps only while the switch conducts
  always @(posedge mclk) begin
    on_q <= gate_drive ? on_q + 16'h0001 : 16'h0000;
    lim_q <= #1 gate_drive && (on_q >= trip_cyc);
  end
  assign current_over_limit = lim_q;
endmodule // oosc_switch_model

// ### testbench/oosc_on_off_switch_controller_tb.sv
`timescale 1ns/100ps
module oosc_on_off_switch_controller_tb;
  localparam int PER = oosc_pkg::CLK_HZ / oosc_pkg::FSW_100_HZ;
  localparam int FPER = PER * 100 / oosc_pkg::FOLD_MIN_PCT;
  localparam int LEB = oosc_pkg::LEB_CYC;
  logic mclk, rst_b, fb_current_over, fb_above_restart, supply_below_low, supply_above_high;
  logic temp_above_trip, temp_below_release, current_over_limit;
  logic gate_drive, cycle_start, max_duty_window, regulation_enable;
  logic [oosc_pkg::FOLD_W-1:0] fb_fold_level;
  logic [15:0] trip_cyc;
  int err_total, n_tests, cyc, per, win, hi, k, p0;
  oosc_on_off_switch_controller #(.FSW_HZ(oosc_pkg::FSW_100_HZ), .AR_DET_CYC(200), .AR_OFF_CYC(6000),
    .AR_ON_CYC(200)) i_dut (.mclk, .rst_b, .fb_current_over, .fb_above_restart, .fb_fold_level,
    .supply_below_low, .supply_above_high, .temp_above_trip, .temp_below_release, .current_over_limit,
    .gate_drive, .cycle_start, .max_duty_window, .regulation_enable);
  oosc_switch_model i_sw (.mclk, .gate_drive, .trip_cyc, .current_over_limit);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_total = err_total + 1;
      conclude();
    end
  end
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, s);
    end
  endtask
  function logic [31:0] inr(input int v, input int lo, input int h);
    return (v >= lo && v <= h) ? 32'h1 : 32'h0;
  endfunction
  task conclude;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task ticks(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    ticks(5);
    s = 1'b0;
  endtask
  // One full switching cycle from a start pulse
  task meas;
    k = 0;
    while (cycle_start !== 1'b1 && k < 12000) begin
      ticks(1);
      k++;
    end
    per = 0;
    win = 0;
    hi = 0;
    do begin
      win += (max_duty_window === 1'b1);
      hi += (gate_drive === 1'b1);
      per++;
      ticks(1);
    end while (cycle_start !== 1'b1 && per < 12000);
  endtask
  task t_lockout;
    meas;
    check("lockout_gate", hi, 0);
    supply_above_high = 1'b1;
    meas;
    meas;
    check("gate_run", inr(hi, win - 2, win), 1);
    check("reg_en", regulation_enable, 1);
  endtask
  task t_period;
    meas;
    check("per_nom", inr(per, PER * 94 / 100, PER * 106 / 100), 1);
    check("win_pct", inr(win * 100 / per, 64, 66), 1);
    p0 = per;
    fb_fold_level = 4'h0;
    meas;
    meas;
    check("per_fold", inr(per, FPER * 94 / 100, FPER * 106 / 100), 1);
    fb_fold_level = 4'hF;
    meas;
  endtask
  task t_disable;
    fb_current_over = 1'b1;
    meas;
    check("late_fb", inr(hi, win - 2, win), 1);
    check("jitter", inr(per - p0, 1, PER * oosc_pkg::JIT_PCT / 100), 1);
    meas;
    check("off_gate", hi, 0);
    check("off_en", regulation_enable, 0);
    fb_current_over = 1'b0;
    meas;
  endtask
  task t_limit;
    trip_cyc = 16'h0000;
    meas;
    meas;
    check("limit_on", inr(hi, LEB, LEB + 4), 1);
    trip_cyc = 16'hFFFF;
    meas;
  endtask
  task t_thermal;
    pulse(temp_above_trip);
    meas;
    meas;
    check("hot_gate", hi, 0);
    pulse(temp_below_release);
    meas;
    meas;
    check("cool_gate", inr(hi, win - 2, win), 1);
  endtask
  task t_uvlo;
    supply_above_high = 1'b0;
    pulse(supply_below_low);
    meas;
    meas;
    check("uv_gate", hi, 0);
    supply_above_high = 1'b1;
    meas;
    meas;
    check("uv_back", inr(hi, win - 2, win), 1);
  endtask
  task t_restart;
    fb_above_restart = 1'b0;
    ticks(150);
    fb_above_restart = 1'b1;
    ticks(10);
    fb_above_restart = 1'b0;
    ticks(150);
    fb_above_restart = 1'b1;
    meas;
    meas;
    check("dip_run", inr(hi, win - 2, win), 1);
    fb_current_over = 1'b1;
    meas;
    fb_current_over = 1'b0;
    fb_above_restart = 1'b0;
    ticks(250);
    hi = 0;
    repeat (5900) begin
      hi += (gate_drive === 1'b1);
      ticks(1);
    end
    check("ar_off", hi, 0);
    fb_above_restart = 1'b1;
    meas;
    meas;
    check("ar_back", inr(hi, win - 2, win), 1);
  endtask
  initial begin
    rst_b = 1'b0;
    fb_current_over = 1'b0;
    fb_above_restart = 1'b1;
    supply_below_low = 1'b0;
    supply_above_high = 1'b0;
    temp_above_trip = 1'b0;
    temp_below_release = 1'b0;
    fb_fold_level = 4'hF;
    trip_cyc = 16'hFFFF;
    ticks(4);
    rst_b = 1'b1;
    t_lockout();
    t_period();
    t_disable();
    t_limit();
    t_thermal();
    t_uvlo();
    t_restart();
    conclude();
  end
endmodule // oosc_on_off_switch_controller_tb
